/* File: rtl/swdt_cfg.svh */
// register offsets, field positions, reset values and timeout exponents of the watchdog
`ifndef SWDT_CFG_SVH
`define SWDT_CFG_SVH

// register byte offsets on the peripheral bus
`define SWDT_CTRL_OFS 12'h000
`define SWDT_RESTART_OFS 12'h004
`define SWDT_STATUS_OFS 12'h008
`define SWDT_COUNT_OFS 12'h00C

// control register layout
`define SWDT_CTRL_RST 8'h00
`define SWDT_EN_BIT 0
`define SWDT_LOCK_BIT 1
`define SWDT_RSP_LSB 2
`define SWDT_RSP_MSB 3
`define SWDT_TOP_LSB 4
`define SWDT_TOP_MSB 6
`define SWDT_RSVD_BIT 7

// status register layout
`define SWDT_STAT_FLAG_BIT 0
`define SWDT_STAT_RUN_BIT 1

// restart key and response codes
`define SWDT_KEY 16'hA5A5
`define SWDT_RSP_FIQ 2'h0
`define SWDT_RSP_RESET 2'h3

// timeout exponents, cycles = 2**exp
`define SWDT_EXP_C0 5'h15
`define SWDT_EXP_C1 5'h16
`define SWDT_EXP_C2 5'h17
`define SWDT_EXP_C3 5'h18
`define SWDT_EXP_C4 5'h19
`define SWDT_EXP_C5 5'h1A
`define SWDT_EXP_C6 5'h1D
`define SWDT_EXP_C7 5'h1F

`endif

/* File: rtl/swdt_pkg.sv */
// types shared by the watchdog modules
package swdt_pkg;
  typedef enum logic [2:0] {
    SWDT_REG_CTRL,
    SWDT_REG_RESTART,
    SWDT_REG_STATUS,
    SWDT_REG_COUNT,
    SWDT_REG_NONE
  } swdt_reg_e;

  typedef enum logic [1:0] {
    SWDT_ACT_NONE,
    SWDT_ACT_IRQ,
    SWDT_ACT_RESET
  } swdt_action_e;

  typedef logic [31:0] swdt_word_t;
endpackage

/* File: rtl/swdt_period_counter.sv */
// free counter that restarts itself after a programmable number of cycles
`timescale 1ns/1ps
module swdt_period_counter
  import swdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [WIDTH-1:0] terminal,
  // state
  output logic [WIDTH-1:0] count,
  output logic hit
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  // timeout when the last cycle of the interval is reached while running
  assign hit = run && (count_ff == terminal);
  assign count = count_ff;

  // restart, stop or wrap all start a fresh interval at zero
  always_comb begin
    if (restart || !run || hit) begin
      nxt_count = '0;
    end else begin
      nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule

/* File: rtl/swdt_top.sv */
// system watchdog: apb register slave, timeout counter and two-stage response
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "swdt_cfg.svh"
module swdt_top
  import swdt_pkg::*;
#(
  parameter int PERIOD_SHIFT = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timeout responses
  output logic fiq_req,
  output logic sys_reset_req
);

  // register decode, shared by read capture and write strobe
  function automatic swdt_reg_e reg_decode(input logic [11:0] addr);
    case (addr)
      `SWDT_CTRL_OFS: reg_decode = SWDT_REG_CTRL;
      `SWDT_RESTART_OFS: reg_decode = SWDT_REG_RESTART;
      `SWDT_STATUS_OFS: reg_decode = SWDT_REG_STATUS;
      `SWDT_COUNT_OFS: reg_decode = SWDT_REG_COUNT;
      default: reg_decode = SWDT_REG_NONE;
    endcase
  endfunction

  // timeout code to exponent of the interval length
  function automatic logic [4:0] top_exp(input logic [2:0] code);
    case (code)
      3'h0: top_exp = `SWDT_EXP_C0;
      3'h1: top_exp = `SWDT_EXP_C1;
      3'h2: top_exp = `SWDT_EXP_C2;
      3'h3: top_exp = `SWDT_EXP_C3;
      3'h4: top_exp = `SWDT_EXP_C4;
      3'h5: top_exp = `SWDT_EXP_C5;
      3'h6: top_exp = `SWDT_EXP_C6;
      default: top_exp = `SWDT_EXP_C7;
    endcase
  endfunction

  // last count of the interval; the shift lets simulation shorten every period
  function automatic swdt_word_t top_terminal(input logic [2:0] code);
    logic [4:0] e;
    e = top_exp(code) - 5'(PERIOD_SHIFT);
    top_terminal = (32'h1 << e) - 32'h1;
  endfunction

  logic [7:0] ctrl_ff;
  logic flag_ff;
  logic sys_reset_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] count;
  logic hit;
  logic ctrl_en;
  logic ctrl_lock;
  logic [1:0] ctrl_rsp;
  logic [2:0] ctrl_top;
  logic [31:0] terminal;
  logic setup_phase;
  logic access_done;
  logic wr_ctrl;
  logic wr_restart;
  logic key_ok;
  logic restart_valid;
  swdt_reg_e sel_reg;
  swdt_action_e action;
  logic [7:0] nxt_ctrl;
  logic [31:0] nxt_prdata;

  // control fields
  assign ctrl_en = ctrl_ff[`SWDT_EN_BIT];
  assign ctrl_lock = ctrl_ff[`SWDT_LOCK_BIT];
  assign ctrl_rsp = ctrl_ff[`SWDT_RSP_MSB:`SWDT_RSP_LSB];
  assign ctrl_top = ctrl_ff[`SWDT_TOP_MSB:`SWDT_TOP_LSB];
  assign terminal = top_terminal(ctrl_top);

  // bus phases: a write lands only on the edge where pready is seen high
  assign sel_reg = reg_decode(paddr);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_ff;
  assign wr_ctrl = access_done && pwrite && (sel_reg == SWDT_REG_CTRL);
  assign wr_restart = access_done && pwrite && (sel_reg == SWDT_REG_RESTART);
  assign key_ok = (pwdata[15:0] == `SWDT_KEY);
  assign restart_valid = wr_restart && key_ok;

  // interval counter; counts only while enabled and restarts on a good key
  swdt_period_counter #(
    .WIDTH(32)
  ) u_counter (
    .clk(clk),
    .reset(reset),
    .run(ctrl_en),
    .restart(restart_valid),
    .terminal(terminal),
    .count(count),
    .hit(hit)
  );

  // what a timeout does: the reset code acts at once, any other code
  // warns first, and an unanswered warning escalates to reset
  always_comb begin
    action = SWDT_ACT_NONE;
    if (hit) begin
      if (ctrl_rsp == `SWDT_RSP_RESET) begin
        action = SWDT_ACT_RESET;
      end else if (flag_ff) begin
        action = SWDT_ACT_RESET;
      end else begin
        action = SWDT_ACT_IRQ;
      end
    end
  end

  // control register; lock is set-only and freezes the enable bit
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = pwdata[7:0];
      nxt_ctrl[`SWDT_RSVD_BIT] = 1'b0;
      nxt_ctrl[`SWDT_LOCK_BIT] = ctrl_lock | pwdata[`SWDT_LOCK_BIT];
      if (ctrl_lock) begin
        nxt_ctrl[`SWDT_EN_BIT] = ctrl_en;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= `SWDT_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // first-timeout flag; a timeout in the restart cycle still sets it
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_ff <= 1'b0;
    end else if (action == SWDT_ACT_IRQ) begin
      flag_ff <= 1'b1;
    end else if (restart_valid) begin
      flag_ff <= 1'b0;
    end
  end

  // one-cycle reset request; the system reset logic feeds back on reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sys_reset_ff <= 1'b0;
    end else begin
      sys_reset_ff <= (action == SWDT_ACT_RESET);
    end
  end

  // read data is snapshot in the setup cycle so it stays put during access
  always_comb begin
    nxt_prdata = 32'h0;
    case (sel_reg)
      SWDT_REG_CTRL: nxt_prdata = {24'h0, ctrl_ff};
      SWDT_REG_STATUS: begin
        nxt_prdata[`SWDT_STAT_FLAG_BIT] = flag_ff;
        nxt_prdata[`SWDT_STAT_RUN_BIT] = ctrl_en;
      end
      SWDT_REG_COUNT: nxt_prdata = count;
      default: nxt_prdata = 32'h0; // restart key reads as zero
    endcase
  end

  // no wait state: pready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup_phase;
      pslverr_ff <= setup_phase && (sel_reg == SWDT_REG_NONE);
      if (setup_phase) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fiq_req = flag_ff; // level; the controller takes its rising edge
  assign sys_reset_req = sys_reset_ff;

  // ------------------------------------------------------------------
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // helper: last count of the interval recomputed independently of the function
  logic [31:0] chk_terminal;
  always_comb begin
    chk_terminal = 32'h0;
    case (ctrl_top)
      3'h0: chk_terminal = (32'h1 << (21 - PERIOD_SHIFT)) - 32'h1;
      3'h1: chk_terminal = (32'h1 << (22 - PERIOD_SHIFT)) - 32'h1;
      3'h2: chk_terminal = (32'h1 << (23 - PERIOD_SHIFT)) - 32'h1;
      3'h3: chk_terminal = (32'h1 << (24 - PERIOD_SHIFT)) - 32'h1;
      3'h4: chk_terminal = (32'h1 << (25 - PERIOD_SHIFT)) - 32'h1;
      3'h5: chk_terminal = (32'h1 << (26 - PERIOD_SHIFT)) - 32'h1;
      3'h6: chk_terminal = (32'h1 << (29 - PERIOD_SHIFT)) - 32'h1;
      default: chk_terminal = (32'h1 << (31 - PERIOD_SHIFT)) - 32'h1;
    endcase
  end

  sequence first_timeout_s;
    hit && (ctrl_rsp != `SWDT_RSP_RESET) && !flag_ff;
  endsequence

  sequence warned_s;
    flag_ff && fiq_req && !sys_reset_req;
  endsequence

  sequence second_timeout_s;
    hit && (ctrl_rsp != `SWDT_RSP_RESET) && flag_ff;
  endsequence

  count_step_a: assert property (
    ctrl_en && !hit && !restart_valid && !wr_ctrl && $stable(ctrl_ff)
      |=> count == $past(count) + 32'h1)
    else $error("counter did not advance by one");

  period_len_a: assert property (
    ctrl_en && $stable(ctrl_top) && count == chk_terminal |-> hit ##1 count == 32'h0)
    else $error("timeout not at selected interval length");

  reset_resp_a: assert property (
    hit && ctrl_rsp == `SWDT_RSP_RESET |=> sys_reset_req && !$rose(fiq_req))
    else $error("reset response did not reset at once");

  first_irq_a: assert property (
    first_timeout_s |=> warned_s)
    else $error("first timeout did not raise flag and interrupt");

  second_reset_a: assert property (
    second_timeout_s |=> sys_reset_req ##1 !sys_reset_req)
    else $error("second timeout did not force one reset pulse");

  restart_key_a: assert property (
    restart_valid && ctrl_en |=> count == 32'h0 ##1 count == 32'h1)
    else $error("valid key did not restart interval");

  lock_hold_a: assert property (
    ctrl_lock |=> ctrl_lock && $stable(ctrl_en))
    else $error("locked enable changed or lock cleared");

  idle_off_a: assert property (
    !ctrl_en |=> count == 32'h0 && !sys_reset_req)
    else $error("disabled watchdog counted or reset");

  bad_key_a: assert property (
    wr_restart && !key_ok && ctrl_en && !hit && $stable(ctrl_ff)
      |=> count == $past(count) + 32'h1)
    else $error("wrong key disturbed counter");

  flag_clear_a: assert property (
    restart_valid && !hit |=> !flag_ff && !fiq_req)
    else $error("valid restart did not clear flag");

  bus_wait_a: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");

endmodule

/* File: testbench/swdt_sys_model.sv */
// system side beside the watchdog: reset loop and fast-interrupt edge counter
`timescale 1ns/1ps
module swdt_sys_model (
  // clock and power-on reset
  input wire logic clk,
  input wire logic por,
  // watchdog requests
  input wire logic fiq_req,
  input wire logic sys_reset_req,
  // system side
  output logic reset,
  output int fiq_count
);
  logic [1:0] hold_ff;
  logic fiq_ff;

  // a one-cycle request is stretched so every block sees a full reset
  always_ff @(posedge clk) begin
    if (por) begin
      hold_ff <= 2'h0;
    end else if (sys_reset_req === 1'b1) begin
      hold_ff <= 2'h3;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
    end
  end

  // the fast-interrupt input is edge triggered, so only rises are counted
  always_ff @(posedge clk) begin
    fiq_ff <= fiq_req;
    if (por) begin
      fiq_count <= 0;
    end else if (fiq_req === 1'b1 && fiq_ff !== 1'b1) begin
      fiq_count <= fiq_count + 1;
    end
  end

  assign reset = por | (hold_ff != 2'h0);
endmodule

/* File: testbench/swdt_top_tb.sv */
// self-checking bench for the system watchdog with its reset loop
`timescale 1ns/1ps
`include "swdt_cfg.svh"
module swdt_top_tb
  import swdt_pkg::*;
;
  localparam int SHIFT = 15;
  logic clk, por, reset, psel, penable, pwrite, pready, pslverr, fiq_req, sys_reset_req, err;
  logic [11:0] paddr;
  swdt_word_t pwdata, prdata, rd, lfsr_ff;
  int err_count, num_checks, fiq_count, cycles, n, fiq_seen;

  swdt_top #(.PERIOD_SHIFT(SHIFT)) swdt_top_i (.clk(clk), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fiq_req(fiq_req), .sys_reset_req(sys_reset_req));
  swdt_sys_model swdt_sys_model_i (.clk(clk), .por(por), .fiq_req(fiq_req),
    .sys_reset_req(sys_reset_req), .reset(reset), .fiq_count(fiq_count));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, sized above the longest period sweep
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 98000) begin
      err_count++;
      summarize();
    end
  end

  function automatic int period(input int c);
    int e[8] = '{21, 22, 23, 24, 25, 26, 29, 31};
    return 1 << (e[c] - SHIFT);
  endfunction

  function automatic swdt_word_t lfsr(input swdt_word_t s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high at an edge,
  // takes the answer at that edge, then lets one more edge pass so the
  // effect of the write is visible when the task returns
  task automatic apb(input logic wr, input logic [11:0] a, input swdt_word_t d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // counts edges from the call, after a write or an earlier request, until the chosen request shows
  task automatic measure(input logic rst_kind, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while ((rst_kind ? sys_reset_req : fiq_req) !== 1'b1 && cnt < 70000);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    por = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    lfsr_ff = 32'h00012617; // seed 75287
    repeat (6) @(posedge clk);
    por <= 1'b0;
    apb(1'b0, `SWDT_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    // every period code under the interrupt response
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `SWDT_CTRL_OFS, 32'(c << 4) | 32'h1);
      measure(1'b0, n);
      chk(n, period(c));
      apb(1'b0, `SWDT_STATUS_OFS, 32'h0);
      chk(rd, 32'h3);
      lfsr_ff = lfsr(lfsr_ff);
      apb(1'b1, `SWDT_RESTART_OFS, lfsr_ff[15:0] == 16'hA5A5 ? 32'h0 : lfsr_ff);
      chk(fiq_req, 1'b1);
      apb(1'b1, `SWDT_CTRL_OFS, 32'h0);
      apb(1'b1, `SWDT_RESTART_OFS, 32'h0000A5A5);
      chk(fiq_req, 1'b0);
    end
    // reset response skips the interrupt stage
    fiq_seen = fiq_count;
    apb(1'b1, `SWDT_CTRL_OFS, 32'h0000000D);
    measure(1'b1, n);
    chk(n, 64);
    chk(fiq_count, fiq_seen);
    repeat (5) @(posedge clk);
    apb(1'b0, `SWDT_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    // locked enable, kept alive by restarts at random spacing
    apb(1'b1, `SWDT_CTRL_OFS, 32'h3);
    for (int i = 0; i < 20; i++) begin
      lfsr_ff = lfsr(lfsr_ff);
      repeat (lfsr_ff[5:0] % 48) @(posedge clk);
      apb(1'b1, `SWDT_RESTART_OFS, {lfsr_ff[31:16], 16'hA5A5});
      chk(fiq_req, 1'b0);
    end
    apb(1'b1, `SWDT_CTRL_OFS, 32'h0);
    apb(1'b0, `SWDT_CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `SWDT_RESTART_OFS, 32'h0000A5A5);
    measure(1'b0, n);
    chk(n, 64);
    measure(1'b1, n);
    chk(n, 64);
    repeat (5) @(posedge clk);
    chk(fiq_req, 1'b0);
    apb(1'b0, `SWDT_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `SWDT_RESTART_OFS, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
